// [shared/sntp_mem_if.sv]
// Port bundle between the packetizer and its byte buffer
`timescale 1ns/1ps
interface sntp_mem_if;
    logic                         we;
    logic [sntp_pkg::BUF_AW-1:0]  waddr;
    logic [7:0]                   wdata;
    logic                         re;
    logic [sntp_pkg::BUF_AW-1:0]  raddr;
    logic [7:0]                   rdata;
    modport ctl (output we, waddr, wdata, re, raddr, input rdata);
    modport mem (input we, waddr, wdata, re, raddr, output rdata);
endinterface

// [shared/sntp_pkg.sv]
// Constants and types shared by the serial-to-network packetizer
package sntp_pkg;
    // ------------------------------------------------------------
    // Buffer geometry
    // ------------------------------------------------------------
    localparam int          BUF_AW    = 10;
    localparam int          PTR_W     = 11;
    localparam logic [10:0] BUF_LIMIT = 11'h400;
    localparam logic [10:0] PTR_ONE   = 11'h001;

    // ------------------------------------------------------------
    // Timing: one millisecond tick at 200 MHz
    // ------------------------------------------------------------
    localparam int CLK_NS = 5;
    localparam int MS_NS  = 1000000;
    localparam int MS_CYC = MS_NS / CLK_NS;
    localparam int TICK_W = 18;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] REG_PKTLEN = 8'h00;
    localparam logic [7:0] REG_DELIM  = 8'h04;
    localparam logic [7:0] REG_FORCE  = 8'h08;
    localparam logic [7:0] REG_INACT  = 8'h0C;
    localparam logic [7:0] REG_CONN   = 8'h10;
    localparam logic [7:0] REG_STAT   = 8'h14;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int DLM_D2_LSB   = 8;
    localparam int DLM_EN1      = 16;
    localparam int DLM_EN2      = 17;
    localparam int DLM_PROC_LSB = 18;
    localparam int CONN_IGN     = 3;
    localparam int CONN_DST_LSB = 4;
    localparam int STAT_CONN    = 16;
    localparam int STAT_DSR     = 17;
    localparam int STAT_DCD     = 18;
    localparam int STAT_OVF     = 19;

    // ------------------------------------------------------------
    // Modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {DP_NONE, DP_PLUS1, DP_PLUS2, DP_STRIP} sntp_dproc_t;
    typedef enum logic [2:0] {
        CC_STARTUP, CC_ANY_NONE, CC_ANY_INACT, CC_DSR_ONOFF,
        CC_DSR_ON, CC_DCD_ONOFF, CC_DCD_ON
    } sntp_conn_t;
    typedef enum logic [1:0] {S_IDLE, S_RD, S_SEND, S_HOSTS} sntp_drain_t;
endpackage

// [sim/sntp_serial_dev.sv]
// Serial device model feeding the packetizer intake
`timescale 1ns/1ps
module sntp_serial_dev (
    // Clock
    input wire logic   clk,
    // Serial lines
    output logic       rx_valid,
    output logic [7:0] rx_data,
    output logic       tx_act,
    output logic       dsr,
    output logic       dcd
);
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        tx_act = 1'b0;
        dsr = 1'b0;
        dcd = 1'b0;
    end
    // Bytes back to back; data inverted once released, so no stale match
    task automatic send(input logic [7:0] b[$]);
        foreach (b[i]) begin
            rx_valid <= 1'b1;
            rx_data <= b[i];
            @(posedge clk);
        end
        rx_valid <= 1'b0;
        rx_data <= ~b[b.size()-1];
    endtask
    task automatic act(input logic v);
        tx_act <= v;
    endtask
    task automatic pin(input logic sel, input logic v);
        if (sel)
            dcd <= v;
        else
            dsr <= v;
    endtask
endmodule

// [sim/sntp_top_monitor.sv]
// Assertion checker for the packetizer top
`timescale 1ns/1ps
module sntp_top_monitor (
    // Clock and reset
    input wire logic       CLK,
    input wire logic       RST,
    // Bus
    input wire logic       WB_CYC_I,
    input wire logic       WB_STB_I,
    input wire logic       WB_ACK_O,
    // Network and connection
    input wire logic       NET_VALID,
    input wire logic       NET_READY,
    input wire logic [7:0] NET_DATA,
    input wire logic       NET_LAST,
    input wire logic [3:0] NET_DEST,
    input wire logic       CONN_REQ,
    input wire logic       DISC_REQ,
    input wire logic       CONNECTED
);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    a_ack_next: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("ack late");
    a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack too long");
    a_net_hold: assert property (NET_VALID && !NET_READY |=> NET_VALID && $stable(NET_DATA)
        && $stable(NET_LAST) && $stable(NET_DEST)) else $error("offer changed");
    a_byte_spacing: assert property (NET_VALID && NET_READY && !NET_LAST
        |=> !NET_VALID ##1 NET_VALID) else $error("packet broken");
    a_last_gap: assert property (NET_VALID && NET_READY && NET_LAST |=> !NET_VALID)
        else $error("no gap after packet");
    a_conn_pulse: assert property (CONN_REQ |=> !CONN_REQ)
        else $error("connect not a pulse");
    a_disc_pulse: assert property (DISC_REQ |=> !DISC_REQ)
        else $error("disconnect not a pulse");
    a_conn_state: assert property (CONN_REQ |-> CONNECTED && !DISC_REQ)
        else $error("connect without state");
    a_disc_state: assert property (DISC_REQ |-> !CONNECTED)
        else $error("disconnect kept state");
    a_conn_cause: assert property ($rose(CONNECTED) |-> CONN_REQ)
        else $error("connected without request");
    c_conn: cover property (CONN_REQ);
    c_disc: cover property (DISC_REQ);
    c_last: cover property (NET_VALID && NET_READY && NET_LAST);
    c_stall: cover property (NET_VALID && !NET_READY);
endmodule
bind sntp_top sntp_top_monitor u_sntp_top_monitor (.CLK, .RST, .WB_CYC_I, .WB_STB_I, .WB_ACK_O,
    .NET_VALID, .NET_READY, .NET_DATA, .NET_LAST, .NET_DEST, .CONN_REQ, .DISC_REQ, .CONNECTED);

// [sim/tb.sv]
// Self-checking bench for the packetizer
`timescale 1ns/1ps
module tb;
    typedef struct {logic [10:0] len; logic [31:0] dlm; int n; logic [8:0] e [4];} sntp_row_t;
    // Each row: length, delimiter word, packet stream {last, byte}
    sntp_row_t rows [8] = '{
        '{11'h002, 32'h0, 4, '{9'h011, 9'h10D, 9'h022, 9'h133}},
        '{11'h000, 32'h0, 4, '{9'h011, 9'h00D, 9'h022, 9'h133}},
        '{11'h000, 32'h1000D, 4, '{9'h011, 9'h10D, 9'h022, 9'h133}},
        '{11'h000, 32'h5000D, 4, '{9'h011, 9'h00D, 9'h122, 9'h133}},
        '{11'h000, 32'h9000D, 4, '{9'h011, 9'h00D, 9'h022, 9'h133}},
        '{11'h000, 32'hD000D, 3, '{9'h111, 9'h022, 9'h133, 9'h0}},
        '{11'h000, 32'h3220D, 4, '{9'h011, 9'h00D, 9'h122, 9'h133}},
        '{11'h000, 32'hF220D, 2, '{9'h111, 9'h133, 9'h0, 9'h0}}};
    logic clk, rst, cyc, stb, we, ready, close, ack, nv, nl, creq, dreq, conn, rxv, txa, dsr, dcd;
    logic [7:0] adr, nd, rxd;
    logic [31:0] wdat, rd, dat_o;
    logic [3:0] done, jam, ndst;
    logic [8:0] got [$];
    logic [7:0] seq [$];
    int bad_count, checked, cyc_n, conn_n, disc_n, m, ed;
    sntp_top #(.MS_CYC(10)) u_sntp_top (.CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(dat_o),
        .WB_ACK_O(ack), .RX_VALID(rxv), .RX_DATA(rxd), .TX_ACT(txa), .DSR(dsr), .DCD(dcd),
        .NET_VALID(nv), .NET_DATA(nd), .NET_LAST(nl), .NET_DEST(ndst), .NET_READY(ready),
        .HOST_DONE(done), .HOST_JAM(jam), .NET_CLOSE(close), .CONN_REQ(creq), .DISC_REQ(dreq),
        .CONNECTED(conn));
    sntp_serial_dev u_sntp_serial_dev (.clk(clk), .rx_valid(rxv), .rx_data(rxd), .tx_act(txa),
        .dsr(dsr), .dcd(dcd));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc_n++;
        if (!rst && nv === 1'b1 && ready === 1'b1)
            got.push_back({nl, nd});
        if (creq === 1'b1)
            conn_n++;
        if (dreq === 1'b1)
            disc_n++;
        // Ceiling well above the roughly 4500 cycles the tests need
        if (cyc_n == 20000) begin
            bad_count++;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("Error at %0t: got %0h expected %0h", $time, g, e);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
            t++;
        end while (ack !== 1'b1 && t < 50);
        rd = dat_o;
        chk(ack, 32'h1);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wait_got(input int n);
        int t;
        t = 0;
        while (got.size() < n && t < n * 3 + 100) begin
            @(posedge clk);
            t++;
        end
        repeat (30) @(posedge clk);
    endtask
    task automatic wrap_up();
        $display("Counts: %0d checked, %0d bad", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        {rst, cyc, stb, we, ready, close} = 6'h22;
        {adr, wdat, done, jam} = {8'h00, 32'h0, 4'hF, 4'h0};
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        wb(1'b0, sntp_pkg::REG_STAT, 32'h0);
        chk(rd, 32'h0);
        wb(1'b0, 8'h18, 32'h0);
        chk(rd, 32'h0);
        wb(1'b1, sntp_pkg::REG_FORCE, 32'h1);
        wb(1'b1, sntp_pkg::REG_INACT, 32'h3);
        chk(conn_n, 0);
        wb(1'b1, sntp_pkg::REG_CONN, 32'h10);
        repeat (5) @(posedge clk);
        chk(conn_n, 1);
        chk(conn, 1);
        $display("Test startup done");
        for (int k = 0; k < 7; k++) begin
            m = (k < 6) ? k + 1 : 2;
            if (k == 6)
                wb(1'b1, sntp_pkg::REG_INACT, 32'h0);
            close <= 1'b1;
            @(posedge clk);
            close <= 1'b0;
            wb(1'b1, sntp_pkg::REG_CONN, 32'h10 | m);
            if (m < 3)
                u_sntp_serial_dev.send('{8'h5A});
            else begin
                u_sntp_serial_dev.pin(m > 4, 1'b1);
                repeat (8) @(posedge clk);
                u_sntp_serial_dev.pin(m > 4, 1'b0);
            end
            if (k == 1) begin
                u_sntp_serial_dev.act(1'b1);
                repeat (40) @(posedge clk);
                chk(disc_n, 0);
                u_sntp_serial_dev.act(1'b0);
            end
            repeat (80) @(posedge clk);
            ed += (m == 3 || m == 5 || (m == 2 && k < 6));
            chk(conn_n, k + 2);
            chk(disc_n, ed);
            $display("Test mode %0d done", m);
        end
        seq = '{8'h11, 8'h0D, 8'h22, 8'h33};
        foreach (rows[i]) begin
            got.delete();
            wb(1'b1, sntp_pkg::REG_PKTLEN, rows[i].len);
            wb(1'b1, sntp_pkg::REG_DELIM, rows[i].dlm);
            u_sntp_serial_dev.send(seq);
            wait_got(rows[i].n);
            chk(got.size(), rows[i].n);
            for (int j = 0; j < rows[i].n; j++)
                chk(got[j], rows[i].e[j]);
            $display("Test row %0d done", i);
        end
        got.delete();
        done <= 4'h1;
        jam <= 4'h2;
        wb(1'b1, sntp_pkg::REG_DELIM, 32'h0);
        wb(1'b1, sntp_pkg::REG_PKTLEN, 32'h1);
        wb(1'b1, sntp_pkg::REG_CONN, 32'h37);
        u_sntp_serial_dev.send('{8'hA1, 8'hA2});
        repeat (60) @(posedge clk);
        chk(got.size(), 1);
        chk(ndst, 4'h3);
        wb(1'b1, sntp_pkg::REG_CONN, 32'h3F);
        wait_got(2);
        chk(got[1], 9'h1A2);
        $display("Test hosts done");
        done <= 4'hF;
        jam <= 4'h0;
        wb(1'b1, sntp_pkg::REG_CONN, 32'h17);
        wb(1'b1, sntp_pkg::REG_FORCE, 32'h0);
        wb(1'b1, sntp_pkg::REG_PKTLEN, 32'h0);
        got.delete();
        seq.delete();
        ready <= 1'b0;
        for (int j = 0; j < 1025; j++)
            seq.push_back(j[7:0]);
        u_sntp_serial_dev.send(seq);
        wb(1'b0, sntp_pkg::REG_STAT, 32'h0);
        chk(rd & 32'h000807FF, 32'h00080400);
        ready <= 1'b1;
        wait_got(1024);
        chk(got.size(), 1024);
        chk(got[1023], 9'h1FF);
        wb(1'b1, sntp_pkg::REG_STAT, 32'h00080000);
        wb(1'b0, sntp_pkg::REG_STAT, 32'h0);
        chk(rd[19], 1'b0);
        u_sntp_serial_dev.send('{8'h77});
        repeat (60) @(posedge clk);
        chk(got.size(), 1024);
        $display("Test full buffer done");
        wrap_up();
    end
endmodule

// [src/sntp_buf.sv]
// Byte buffer, one write and one registered read port
`timescale 1ns/1ps
module sntp_buf (
    // Clock
    input  wire logic clk,
    // Buffer port
    sntp_mem_if.mem   mp
);
    // Array kept outside the state struct so it maps to block RAM
    logic [7:0] mem [0:(1 << sntp_pkg::BUF_AW)-1];
    logic [7:0] rdata;

    always_ff @(posedge clk) begin
        if (mp.we) begin
            mem[mp.waddr] <= mp.wdata;
        end
        if (mp.re) begin
            rdata <= mem[mp.raddr];
        end
    end

    assign mp.rdata = rdata;
endmodule

// [src/sntp_sync.sv]
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
module sntp_sync #(
    parameter int W = 2
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Asynchronous in, synchronous out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sntp_sync_t;

    sntp_sync_t r;
    sntp_sync_t next_r;

    always_comb begin
        next_r.s1 = d;
        next_r.s2 = r.s1;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign q = r.s2;
endmodule

// [src/sntp_top.sv]
// Serial-to-network packetizer with connection control
`timescale 1ns/1ps
// Summary of operation
// - Length zero: flush only on delimiter, full buffer or force-transmit gap.
// - Length 1..1024: flush when the count of bytes since the last flush reaches length.
// - First delimiter enabled: flush when that byte arrives.
// - Both enabled: flush after both bytes; processing needs first delimiter.
// - Flush whenever buffered data reaches the 1 KB ceiling.
// - Default processing: send at delimiter, delimiter bytes included.
// - Plus-one: send after one more byte, included.
// - Plus-two: send after two more bytes, included.
// - Strip: delimiter bytes removed from sent data.
// - Flush when receive gap reaches force-transmit time.
// - Startup mode: connect after startup, never disconnect.
// - Any-character modes connect on a byte; inactivity variant disconnects.
// - DSR modes connect on rise; on/off variant disconnects on fall.
// - DCD modes connect on rise; on/off variant disconnects on fall.
// - Inactivity timer used only in any-character/inactivity mode.
// - Wait for all hosts per group, or skip jammed ones.
// - Up to four destinations; one needed before connecting.
// - Inactivity counts since last serial traffic either direction.
// - Inactivity time zero disables the timeout.
module sntp_top #(
    parameter int MS_CYC = sntp_pkg::MS_CYC
) (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RST,
    // Wishbone slave
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    // Serial side
    input  wire logic        RX_VALID,
    input  wire logic [7:0]  RX_DATA,
    input  wire logic        TX_ACT,
    input  wire logic        DSR,
    input  wire logic        DCD,
    // Network side
    output logic             NET_VALID,
    output logic [7:0]       NET_DATA,
    output logic             NET_LAST,
    output logic [3:0]       NET_DEST,
    input  wire logic        NET_READY,
    input  wire logic [3:0]  HOST_DONE,
    input  wire logic [3:0]  HOST_JAM,
    input  wire logic        NET_CLOSE,
    // Connection requests
    output logic             CONN_REQ,
    output logic             DISC_REQ,
    output logic             CONNECTED
);
    typedef struct packed {
        logic                  ack;
        logic [31:0]           dat;
        logic [10:0]           pkt_len;
        logic [7:0]            d1;
        logic [7:0]            d2;
        logic                  en1;
        logic                  en2;
        sntp_pkg::sntp_dproc_t dproc;
        logic [15:0]           force_ms;
        logic [15:0]           inact_ms;
        sntp_pkg::sntp_conn_t  cmode;
        logic                  ign;
        logic [3:0]            dest;
        logic [10:0]           wr;
        logic [10:0]           cm;
        logic [10:0]           rd;
        logic                  pend;
        logic                  saw_d1;
        logic [1:0]            trail;
        logic [17:0]           tick;
        logic [15:0]           gap;
        logic [15:0]           idle;
        sntp_pkg::sntp_drain_t st;
        logic                  valid;
        logic                  last;
        logic [3:0]            acc;
        logic [3:0]            gdest;
        logic                  conn;
        logic                  started;
        logic                  cre;
        logic                  dre;
        logic                  dsr_q;
        logic                  dcd_q;
        logic                  ovf;
    } sntp_state_t;

    sntp_state_t r;
    sntp_state_t next_r;
    logic [1:0]  pins;
    logic        occ_ok;
    logic        strip_now;

    localparam logic [17:0] TICK_LAST = 18'(MS_CYC - 1);

    sntp_mem_if mif ();

    sntp_buf u_buf (
        .clk (CLK),
        .mp  (mif)
    );

    sntp_sync #(.W(2)) u_sync (
        .clk (CLK),
        .rst (RST),
        .d   ({DCD, DSR}),
        .q   (pins)
    );

    always_comb begin
        logic        hit;
        logic [31:0] rv;
        logic [31:0] bm;
        logic [31:0] wv;
        logic [10:0] occ;
        logic        ms;
        logic        flush;
        logic        wr_en;
        logic        m1;
        logic        dhit;
        logic        strip;
        logic        can;
        logic        conn_ev;
        logic        disc_ev;
        hit     = WB_CYC_I & WB_STB_I;
        rv      = '0;
        wv      = '0;
        ms      = 1'b0;
        can     = 1'b0;
        bm      = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
        occ     = 11'(r.wr - r.rd);
        flush   = 1'b0;
        wr_en   = 1'b0;
        m1      = 1'b0;
        dhit    = 1'b0;
        strip   = 1'b0;
        conn_ev = 1'b0;
        disc_ev = 1'b0;
        next_r  = r;
        next_r.cre = 1'b0;
        next_r.dre = 1'b0;

        // ------------------------------------------------------------
        // Register bus
        // ------------------------------------------------------------
        case ({WB_ADR_I[7:2], 2'b00})
            sntp_pkg::REG_PKTLEN: rv[10:0] = r.pkt_len;
            sntp_pkg::REG_DELIM: begin
                rv[7:0]                       = r.d1;
                rv[sntp_pkg::DLM_D2_LSB +: 8] = r.d2;
                rv[sntp_pkg::DLM_EN1]         = r.en1;
                rv[sntp_pkg::DLM_EN2]         = r.en2;
                rv[sntp_pkg::DLM_PROC_LSB +: 2] = r.dproc;
            end
            sntp_pkg::REG_FORCE: rv[15:0] = r.force_ms;
            sntp_pkg::REG_INACT: rv[15:0] = r.inact_ms;
            sntp_pkg::REG_CONN: begin
                rv[2:0]                         = r.cmode;
                rv[sntp_pkg::CONN_IGN]          = r.ign;
                rv[sntp_pkg::CONN_DST_LSB +: 4] = r.dest;
            end
            sntp_pkg::REG_STAT: begin
                rv[10:0]               = occ;
                rv[sntp_pkg::STAT_CONN] = r.conn;
                rv[sntp_pkg::STAT_DSR]  = r.dsr_q;
                rv[sntp_pkg::STAT_DCD]  = r.dcd_q;
                rv[sntp_pkg::STAT_OVF]  = r.ovf;
            end
            default: rv = '0;
        endcase
        wv = (rv & ~bm) | (WB_DAT_I & bm);
        next_r.ack = hit & ~r.ack;
        if (hit & ~r.ack) begin
            next_r.dat = rv;
        end
        // Write lands on the edge where the master sees ack
        if (hit & r.ack & WB_WE_I) begin
            case ({WB_ADR_I[7:2], 2'b00})
                sntp_pkg::REG_PKTLEN: next_r.pkt_len = wv[10:0];
                sntp_pkg::REG_DELIM: begin
                    next_r.d1    = wv[7:0];
                    next_r.d2    = wv[sntp_pkg::DLM_D2_LSB +: 8];
                    next_r.en1   = wv[sntp_pkg::DLM_EN1];
                    next_r.en2   = wv[sntp_pkg::DLM_EN2];
                    next_r.dproc = sntp_pkg::sntp_dproc_t'(wv[sntp_pkg::DLM_PROC_LSB +: 2]);
                end
                sntp_pkg::REG_FORCE: next_r.force_ms = wv[15:0];
                sntp_pkg::REG_INACT: next_r.inact_ms = wv[15:0];
                sntp_pkg::REG_CONN: begin
                    next_r.cmode = sntp_pkg::sntp_conn_t'(wv[2:0]);
                    next_r.ign   = wv[sntp_pkg::CONN_IGN];
                    next_r.dest  = wv[sntp_pkg::CONN_DST_LSB +: 4];
                end
                sntp_pkg::REG_STAT: begin
                    if (WB_DAT_I[sntp_pkg::STAT_OVF] & WB_SEL_I[2]) begin
                        next_r.ovf = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // ------------------------------------------------------------
        // Millisecond tick and idle timers
        // ------------------------------------------------------------
        ms = (r.tick == TICK_LAST);
        next_r.tick = ms ? '0 : 18'(r.tick + 18'h00001);
        if (ms && r.gap != 16'hFFFF) begin
            next_r.gap = 16'(r.gap + 16'h0001);
        end
        if (ms && r.idle != 16'hFFFF) begin
            next_r.idle = 16'(r.idle + 16'h0001);
        end
        if (RX_VALID | TX_ACT) begin
            next_r.idle = '0;
        end

        // ------------------------------------------------------------
        // Byte intake
        // ------------------------------------------------------------
        if (RX_VALID) begin
            next_r.gap = '0;
            if (occ == sntp_pkg::BUF_LIMIT) begin
                // Drain stalled by the network: byte is lost
                next_r.ovf = 1'b1;
            end else begin
                m1   = r.en1 && RX_DATA == r.d1;
                dhit = r.en1 && (r.en2 ? (r.saw_d1 && RX_DATA == r.d2) : m1);
                next_r.saw_d1 = m1;
                strip = dhit && r.dproc == sntp_pkg::DP_STRIP;
                wr_en = ~strip;
                if (wr_en) begin
                    next_r.wr = 11'(r.wr + sntp_pkg::PTR_ONE);
                end else if (r.en2 && r.wr != r.cm) begin
                    next_r.wr = 11'(r.wr - sntp_pkg::PTR_ONE);
                end
                if (r.trail != 2'h0) begin
                    next_r.trail = 2'(r.trail - 2'h1);
                    flush = (r.trail == 2'h1);
                end else if (dhit) begin
                    case (r.dproc)
                        sntp_pkg::DP_PLUS1: next_r.trail = 2'h1;
                        sntp_pkg::DP_PLUS2: next_r.trail = 2'h2;
                        default: flush = 1'b1;
                    endcase
                end
                if (r.pkt_len != '0 && 11'(next_r.wr - r.cm) == r.pkt_len) begin
                    flush = 1'b1;
                end
                if (11'(next_r.wr - r.rd) == sntp_pkg::BUF_LIMIT) begin
                    flush = 1'b1;
                end
            end
        end else if (r.force_ms != '0 && r.wr != r.cm && r.gap >= r.force_ms) begin
            flush = 1'b1;
        end

        // ------------------------------------------------------------
        // Drain toward the network
        // ------------------------------------------------------------
        case (r.st)
            sntp_pkg::S_RD: begin
                next_r.st    = sntp_pkg::S_SEND;
                next_r.valid = 1'b1;
                next_r.last  = (11'(r.rd + sntp_pkg::PTR_ONE) == r.cm);
            end
            sntp_pkg::S_SEND: begin
                if (NET_READY) begin
                    next_r.valid = 1'b0;
                    next_r.last  = 1'b0;
                    next_r.rd    = 11'(r.rd + sntp_pkg::PTR_ONE);
                    next_r.st    = r.last ? sntp_pkg::S_HOSTS : sntp_pkg::S_RD;
                end
            end
            sntp_pkg::S_HOSTS: begin
                // all hosts, or skip jammed ones
                next_r.acc = r.acc | HOST_DONE | (r.ign ? HOST_JAM : 4'h0);
                if ((next_r.acc & r.gdest) == r.gdest) begin
                    next_r.st = sntp_pkg::S_IDLE;
                end
            end
            default: next_r.st = sntp_pkg::S_IDLE;
        endcase
        // one commit covers every byte so far
        if (flush | r.pend) begin
            if (r.st != sntp_pkg::S_IDLE) begin
                next_r.pend = 1'b1;
            end else begin
                next_r.pend = 1'b0;
                if (next_r.wr != r.cm) begin
                    next_r.cm    = next_r.wr;
                    next_r.st    = sntp_pkg::S_RD;
                    next_r.acc   = '0;
                    next_r.gdest = r.dest;
                end
            end
        end

        // ------------------------------------------------------------
        // Connection control
        // ------------------------------------------------------------
        next_r.dsr_q = pins[0];
        next_r.dcd_q = pins[1];
        can = (r.dest != 4'h0);
        case (r.cmode)
            sntp_pkg::CC_STARTUP: conn_ev = ~r.started;
            sntp_pkg::CC_ANY_NONE: conn_ev = RX_VALID;
            sntp_pkg::CC_ANY_INACT: begin
                conn_ev = RX_VALID;
                disc_ev = r.inact_ms != '0 && r.idle >= r.inact_ms;
            end
            sntp_pkg::CC_DSR_ONOFF: begin
                conn_ev = pins[0] & ~r.dsr_q;
                disc_ev = ~pins[0] & r.dsr_q;
            end
            sntp_pkg::CC_DSR_ON: conn_ev = pins[0] & ~r.dsr_q;
            sntp_pkg::CC_DCD_ONOFF: begin
                conn_ev = pins[1] & ~r.dcd_q;
                disc_ev = ~pins[1] & r.dcd_q;
            end
            sntp_pkg::CC_DCD_ON: conn_ev = pins[1] & ~r.dcd_q;
            default: ;
        endcase
        if (NET_CLOSE) begin
            next_r.conn = 1'b0;
        end
        if (r.conn && disc_ev) begin
            next_r.conn = 1'b0;
            next_r.dre  = 1'b1;
        end else if (~r.conn && conn_ev && can) begin
            // Event wins over a close in the same cycle
            next_r.conn    = 1'b1;
            next_r.cre     = 1'b1;
            next_r.started = 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // Buffer ports and outputs
    // ------------------------------------------------------------
    assign mif.we    = RX_VALID && occ_ok && !strip_now;
    assign mif.waddr = r.wr[sntp_pkg::BUF_AW-1:0];
    assign mif.wdata = RX_DATA;
    assign mif.re    = (r.st == sntp_pkg::S_RD);
    assign mif.raddr = r.rd[sntp_pkg::BUF_AW-1:0];

    assign occ_ok    = (11'(r.wr - r.rd) != sntp_pkg::BUF_LIMIT);
    assign strip_now = (r.dproc == sntp_pkg::DP_STRIP) && r.en1 &&
                       (r.en2 ? (r.saw_d1 && RX_DATA == r.d2) : (RX_DATA == r.d1));

    assign WB_ACK_O  = r.ack;
    assign WB_DAT_O  = r.dat;
    assign NET_VALID = r.valid;
    assign NET_DATA  = mif.rdata;
    assign NET_LAST  = r.last;
    assign NET_DEST  = r.gdest;
    assign CONN_REQ  = r.cre;
    assign DISC_REQ  = r.dre;
    assign CONNECTED = r.conn;
endmodule
